// ### logic/adc_ctrl_pkg.sv
// constants, register map and state type of the converter control block
package adc_ctrl_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [5:0] OFF_CFG = 6'h00;
    localparam logic [5:0] OFF_SC2 = 6'h04;
    localparam logic [5:0] OFF_SC1 = 6'h08;
    localparam logic [5:0] OFF_RES_HI = 6'h0c;
    localparam logic [5:0] OFF_RES_LO = 6'h10;
    localparam logic [5:0] OFF_CMP_HI = 6'h14;
    localparam logic [5:0] OFF_CMP_LO = 6'h18;
    localparam logic [5:0] OFF_PCTL1 = 6'h1c;
    localparam logic [5:0] OFF_PCTL2 = 6'h20;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CFG_LPC = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LSMP = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_CLK_LSB = 0;
    localparam int SC2_ACT = 7;
    localparam int SC2_TRG = 6;
    localparam int SC2_CFE = 5;
    localparam int SC2_CGT = 4;
    localparam int SC1_DONE = 7;
    localparam int SC1_IRQ_EN = 6;
    localparam int SC1_CONT = 5;
    // ****************************************
    // encodings and reset values
    // ****************************************
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_BUS_HALF = 2'h1;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    localparam logic [4:0] CH_OFF = 5'h1f;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // timing, in conversion clock cycles, bus clock cycles and ns
    // ****************************************
    localparam logic [5:0] CONV_SHORT_LAST = 6'd19;
    localparam logic [5:0] CONV_LONG_LAST = 6'd39;
    localparam logic [5:0] CONV_10BIT_EXTRA = 6'd3;
    localparam int CLK_PERIOD_NS = 4;
    localparam int ASYNC_PERIOD_NS = 8;
    localparam int ASYNC_DIV = ASYNC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int ASYNC_STARTUP_NS = 5000;
    localparam int ASYNC_STARTUP_CYC = (ASYNC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {ST_IDLE, ST_WARM, ST_CONV} state_t;
endpackage : adc_ctrl_pkg

// ### logic/adc_ctrl.sv
// converter control: axi4-lite registers, conversion sequencing, stop mode handling
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module adc_ctrl
(
    input wire logic aclk, // bus clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [5:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [5:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic stop3_mode, // shallow stop level, same clock
    input wire logic deep_stop, // stop1/stop2 level, same clock
    input wire logic hw_trigger, // hardware trigger pin, asynchronous
    input wire logic [9:0] sample_value, // converter core result, same clock
    output logic [4:0] sample_channel, // selected analog channel
    output logic conv_busy, // conversion in progress
    output logic conv_irq, // completion interrupt, wakes the cpu
    output logic [15:0] pin_disable // digital i/o disable per analog pin
);
    import adc_ctrl_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [7:0] cfg_q;
    logic [2:0] sc2_q;
    logic [6:0] sc1_q;
    logic done_flag_q;
    logic [9:0] res_q;
    logic [9:0] cmp_q;
    logic [7:0] pctl1_q;
    logic [7:0] pctl2_q;
    logic half_read_q;
    state_t state_q;
    state_t state_d;
    logic [5:0] cnt_q;
    logic [2:0] div_q;
    logic half_q;
    logic [7:0] async_q;
    logic [10:0] warm_q;
    logic trg1_q, trg2_q, trg3_q;
    logic aw_full_q, w_full_q;
    logic [5:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [4:0] chan_q;
    logic busy_q, irq_q;
    logic [15:0] pin_q;

    // ****************************************
    // bus decode
    // ****************************************
    wire rst_reg = !aresetn || deep_stop;
    wire aw_fire = awvalid && awready_q;
    wire w_fire = wvalid && wready_q;
    wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
    wire ar_fire = arvalid && arready_q;
    wire wr_hit = wr_fire && w_lane_q;
    wire wr_cfg = wr_hit && aw_addr_q == OFF_CFG;
    wire wr_sc2 = wr_hit && aw_addr_q == OFF_SC2;
    wire wr_sc1 = wr_hit && aw_addr_q == OFF_SC1;
    wire wr_cmph = wr_hit && aw_addr_q == OFF_CMP_HI;
    wire wr_cmpl = wr_hit && aw_addr_q == OFF_CMP_LO;
    wire wr_pc1 = wr_hit && aw_addr_q == OFF_PCTL1;
    wire wr_pc2 = wr_hit && aw_addr_q == OFF_PCTL2;
    wire wr_mode = wr_cfg || wr_sc2 || wr_cmph || wr_cmpl;
    wire aw_mapped = aw_addr_q <= OFF_PCTL2 && aw_addr_q[1:0] == 2'h0;
    wire ar_mapped = araddr <= OFF_PCTL2 && araddr[1:0] == 2'h0;
    wire rd_hi = ar_fire && araddr == OFF_RES_HI;
    wire rd_lo = ar_fire && araddr == OFF_RES_LO;

    // ****************************************
    // configuration fields
    // ****************************************
    wire [1:0] div_sel = cfg_q[CFG_DIV_LSB +: 2];
    wire long_smp = cfg_q[CFG_LSMP];
    wire is10 = cfg_q[CFG_MODE_LSB +: 2] == MODE_10BIT;
    wire [1:0] clk_sel = cfg_q[CFG_CLK_LSB +: 2];
    wire async_sel = clk_sel == CLK_ASYNC;
    wire hw_trg_sel = sc2_q[2];
    wire cmp_en = sc2_q[1];
    wire cmp_gt = sc2_q[0];
    wire irq_en = sc1_q[SC1_IRQ_EN];
    wire cont = sc1_q[SC1_CONT];
    wire [4:0] chan = sc1_q[4:0];

    // ****************************************
    // conversion clock enable
    // ****************************************
    // the alternate clock input is not present; it falls back to bus/2
    wire src_tick = (clk_sel == CLK_BUS) ? 1'b1 :
                    async_sel ? (async_q == 8'(ASYNC_DIV - 1)) : half_q;
    wire [2:0] div_mask = 3'((4'h1 << div_sel) - 4'h1);
    wire conv_tick = src_tick && ((div_q & div_mask) == div_mask);

    // ****************************************
    // conversion sequencing
    // ****************************************
    wire busy = state_q != ST_IDLE;
    wire stop_abort = stop3_mode && !async_sel;
    wire hw_rise = trg2_q && !trg3_q;
    wire [4:0] new_ch = w_data_q[4:0];
    wire sw_start = wr_sc1 && new_ch != CH_OFF && !hw_trg_sel;
    wire hw_start = hw_trg_sel && hw_rise && chan != CH_OFF && !busy && !stop_abort;
    wire start_any = sw_start || hw_start;
    wire [5:0] conv_last = (long_smp ? CONV_LONG_LAST : CONV_SHORT_LAST) +
                           (is10 ? CONV_10BIT_EXTRA : 6'd0);
    wire done = state_q == ST_CONV && conv_tick && cnt_q == conv_last;
    wire [9:0] sample = is10 ? sample_value : {2'h0, sample_value[9:2]};
    wire cmp_ok = !cmp_en || (cmp_gt ? sample >= cmp_q : sample < cmp_q);
    wire blocked = is10 && half_read_q;
    wire xfer = done && cmp_ok && !blocked;
    wire again = cont || (blocked && !(cmp_en && !cmp_ok));
    wire [9:0] res_new = cmp_en ? 10'(sample - cmp_q) : sample;
    wire done_flag_set = xfer;
    wire done_flag_clr = wr_sc1 || rd_lo;
    wire done_flag_d = done_flag_set || (done_flag_q && !done_flag_clr);
    wire warm_done = warm_q == 11'(ASYNC_STARTUP_CYC - 1);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start_any)
                    state_d = async_sel ? ST_WARM : ST_CONV;
            end
            ST_WARM:
            begin
                if (warm_done)
                    state_d = ST_CONV;
            end
            ST_CONV:
            begin
                if (done)
                    state_d = again ? ST_CONV : ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        if (wr_sc1)
            state_d = sw_start ? (async_sel ? ST_WARM : ST_CONV) : ST_IDLE;
        else if (wr_mode || stop_abort)
            state_d = ST_IDLE;
    end

    always_ff @(posedge aclk)
    begin
        if (rst_reg)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 6'h00;
            warm_q <= 11'h000;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= (state_d != state_q || done || wr_sc1) ? 6'h00 : cnt_q + 6'(conv_tick);
            warm_q <= (state_q == ST_WARM && !wr_sc1) ? warm_q + 11'h001 : 11'h000;
        end
    end

    // clock dividers run free; a conversion may start mid-period, costing one tick at most
    always_ff @(posedge aclk)
    begin
        if (rst_reg)
        begin
            div_q <= 3'h0;
            half_q <= 1'b0;
            async_q <= 8'h00;
        end
        else
        begin
            half_q <= !half_q;
            async_q <= (async_q == 8'(ASYNC_DIV - 1)) ? 8'h00 : async_q + 8'h01;
            if (src_tick)
                div_q <= div_q + 3'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trg1_q <= 1'b0;
            trg2_q <= 1'b0;
            trg3_q <= 1'b0;
        end
        else
        begin
            trg1_q <= hw_trigger;
            trg2_q <= trg1_q;
            trg3_q <= trg2_q;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (rst_reg)
        begin
            cfg_q <= RST_REG;
            sc2_q <= 3'h0;
            sc1_q <= 7'(RST_REG | 8'h1f);
            done_flag_q <= 1'b0;
            res_q <= 10'h000;
            cmp_q <= 10'h000;
            pctl1_q <= RST_REG;
            pctl2_q <= RST_REG;
            half_read_q <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
                cfg_q <= w_data_q;
            if (wr_sc2)
                sc2_q <= w_data_q[SC2_CGT +: 3];
            if (wr_sc1)
                sc1_q <= w_data_q[6:0];
            if (wr_cmph)
                cmp_q[9:8] <= w_data_q[1:0];
            if (wr_cmpl)
                cmp_q[7:0] <= w_data_q;
            if (wr_pc1)
                pctl1_q <= w_data_q;
            if (wr_pc2)
                pctl2_q <= w_data_q;
            done_flag_q <= done_flag_d;
            if (xfer)
                res_q <= res_new;
            // set wins over clear when the high byte is read again
            if (rd_hi && is10)
                half_read_q <= 1'b1;
            else if (rd_lo)
                half_read_q <= 1'b0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (rst_reg)
        begin
            chan_q <= CH_OFF;
            busy_q <= 1'b0;
            irq_q <= 1'b0;
            pin_q <= 16'h0000;
        end
        else
        begin
            chan_q <= wr_sc1 ? new_ch : chan;
            busy_q <= state_d != ST_IDLE;
            irq_q <= done_flag_d && (wr_sc1 ? w_data_q[SC1_IRQ_EN] : irq_en);
            pin_q <= {wr_pc2 ? w_data_q : pctl2_q, wr_pc1 ? w_data_q : pctl1_q};
        end
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    wire aw_full_d = (aw_full_q || aw_fire) && !wr_fire;
    wire w_full_d = (w_full_q || w_fire) && !wr_fire;
    wire rvalid_d = (rvalid_q && !rready) || ar_fire;
    wire [31:0] rd_mux =
        araddr == OFF_CFG ? {24'h0, cfg_q} :
        araddr == OFF_SC2 ? {24'h0, busy, sc2_q, 4'h0} :
        araddr == OFF_SC1 ? {24'h0, done_flag_q, sc1_q} :
        araddr == OFF_RES_HI ? {30'h0, res_q[9:8]} :
        araddr == OFF_RES_LO ? {24'h0, res_q[7:0]} :
        araddr == OFF_CMP_HI ? {30'h0, cmp_q[9:8]} :
        araddr == OFF_CMP_LO ? {24'h0, cmp_q[7:0]} :
        araddr == OFF_PCTL1 ? {24'h0, pctl1_q} :
        araddr == OFF_PCTL2 ? {24'h0, pctl2_q} : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 6'h00;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= !aw_full_d;
            wready_q <= !w_full_d;
            if (aw_fire)
                aw_addr_q <= awaddr;
            if (w_fire)
            begin
                w_data_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
            end
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid_q <= 1'b0;
            rvalid_q <= rvalid_d;
            arready_q <= !rvalid_d;
            if (ar_fire)
            begin
                rdata_q <= rd_mux;
                rresp_q <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign sample_channel = chan_q;
    assign conv_busy = busy_q;
    assign conv_irq = irq_q;
    assign pin_disable = pin_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_stop_abort;
        stop3_mode && !async_sel && busy;
    endsequence
    sequence s_half_done;
        done && is10 && half_read_q;
    endsequence

    property p_stop_abort;
        s_stop_abort |=> state_q == ST_IDLE ##1 !conv_busy;
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");
    property p_result_hold;
        !xfer && !deep_stop |=> $stable(res_q);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed");
    property p_idle_wait;
        state_q == ST_IDLE && !start_any |=> state_q == ST_IDLE;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("left idle untriggered");
    property p_async_run;
        stop3_mode && async_sel && busy && !done && !wr_fire && !deep_stop |=> busy;
    endproperty
    a_async_run: assert property (p_async_run) else $error("async run stopped");
    property p_cont_next;
        done && cont && !wr_fire && !deep_stop && !stop_abort |=> state_q == ST_CONV;
    endproperty
    a_cont_next: assert property (p_cont_next) else $error("no continuous restart");
    property p_wake;
        xfer && irq_en && !wr_fire && !deep_stop |=> done_flag_q && conv_irq;
    endproperty
    a_wake: assert property (p_wake) else $error("no completion wake");
    property p_deep_reset;
        deep_stop |=> cfg_q == RST_REG && !done_flag_q && !busy && res_q == 10'h000;
    endproperty
    a_deep_reset: assert property (p_deep_reset) else $error("deep stop kept state");
    property p_block;
        s_half_done |=> $stable(res_q) && !$rose(done_flag_q);
    endproperty
    a_block: assert property (p_block) else $error("half-read pair overwritten");
    property p_sc1_start;
        sw_start && !deep_stop |=> busy ##1 conv_busy;
    endproperty
    a_sc1_start: assert property (p_sc1_start) else $error("control write no start");
    property p_busy_read;
        ar_fire && araddr == OFF_SC2 |=> rdata_q[SC2_ACT] == $past(busy) && rdata_q[3:0] == 4'h0;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("active flag wrong");
endmodule : adc_ctrl

// ### verif/adc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module adc_ctrl_tb;
    import adc_ctrl_pkg::*;
    // ****************************************
    // signals and instance
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic stop3_mode = 1'b0, deep_stop = 1'b0, hw_trigger = 1'b0;
    logic [9:0] sample_value = 10'h000;
    logic awready, wready, bvalid, arready, rvalid, conv_busy, conv_irq;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata;
    logic [4:0] sample_channel;
    logic [15:0] pin_disable;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    always #2 aclk = ~aclk;
    adc_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .stop3_mode(stop3_mode), .deep_stop(deep_stop), .hw_trigger(hw_trigger),
        .sample_value(sample_value), .sample_channel(sample_channel), .conv_busy(conv_busy),
        .conv_irq(conv_irq), .pin_disable(pin_disable));
    // ****************************************
    // shared tasks
    // ****************************************
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // both channels offered together, each released on its own handshake
    task wr(input logic [5:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        last_resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task rchk(input logic [5:0] a, input logic [7:0] exp, input string nm);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        last_resp = rresp;
        rready <= 1'b0;
        chk(nm, rdata, {24'h0, exp});
        @(posedge aclk);
    endtask : rchk
    task wait_irq(input int lim);
        n = 0;
        while (conv_irq !== 1'b1 && n < lim)
        begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_irq
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        rchk(OFF_CFG, 8'h00, "cfg reset");
        rchk(OFF_SC2, 8'h00, "sc2 reset");
        rchk(OFF_SC1, 8'h1f, "sc1 reset");
        chk("channel port", sample_channel, 5'h1f);
        rchk(6'h24, 8'h00, "unmapped read");
        chk("unmapped rresp", last_resp, RESP_SLVERR);
        wr(6'h24, 8'h55);
        chk("unmapped bresp", last_resp, RESP_SLVERR);
        $display("test reset done");
    endtask : t_reset
    task t_regs;
        wr(OFF_CFG, 8'h98);
        rchk(OFF_CFG, 8'h98, "cfg fields");
        wr(OFF_SC2, 8'h7c);
        rchk(OFF_SC2, 8'h70, "sc2 fields");
        wr(OFF_CMP_HI, 8'hff);
        rchk(OFF_CMP_HI, 8'h03, "compare high");
        wr(OFF_PCTL1, 8'h02);
        chk("pin disable", pin_disable, 16'h0002);
        wr(OFF_SC2, 8'h00);
        wr(OFF_CMP_HI, 8'h00);
        wr(OFF_CFG, 8'h00);
        $display("test registers done");
    endtask : t_regs
    task t_single;
        sample_value <= 10'h2a8;
        wr(OFF_SC1, 8'h41);
        chk("channel port", sample_channel, 5'h01);
        wait_irq(200);
        chk("undivided time", (n >= 14 && n <= 30), 1'b1);
        rchk(OFF_SC1, 8'hc1, "sc1 done");
        rchk(OFF_RES_HI, 8'h00, "result high");
        rchk(OFF_RES_LO, 8'haa, "result low");
        rchk(OFF_SC1, 8'h41, "flag cleared");
        $display("test single done");
    endtask : t_single
    task t_abort;
        sample_value <= 10'h100;
        wr(OFF_SC1, 8'h41);
        repeat (3) @(posedge aclk);
        stop3_mode <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("stop abort", conv_busy, 1'b0);
        stop3_mode <= 1'b0;
        repeat (100) @(posedge aclk);
        chk("stay idle", conv_irq, 1'b0);
        rchk(OFF_RES_HI, 8'h00, "kept high");
        rchk(OFF_RES_LO, 8'haa, "kept low");
        $display("test stop abort done");
    endtask : t_abort
    task t_compare;
        sample_value <= 10'h2a8;
        wr(OFF_CMP_LO, 8'h80);
        wr(OFF_SC2, 8'h30);
        wr(OFF_SC1, 8'h41);
        wait_irq(200);
        chk("compare hit", conv_irq, 1'b1);
        rchk(OFF_RES_LO, 8'h2a, "compare diff");
        wr(OFF_CMP_LO, 8'hc0);
        wr(OFF_SC1, 8'h41);
        repeat (60) @(posedge aclk);
        chk("compare miss", conv_irq, 1'b0);
        rchk(OFF_RES_LO, 8'h2a, "miss kept");
        wr(OFF_SC2, 8'h00);
        $display("test compare done");
    endtask : t_compare
    task t_async;
        sample_value <= 10'h0c4;
        wr(OFF_CFG, 8'h03);
        wr(OFF_SC1, 8'h41);
        stop3_mode <= 1'b1;
        rchk(OFF_SC2, 8'h80, "active flag");
        wait_irq(3000);
        chk("stop complete", conv_irq, 1'b1);
        rchk(OFF_RES_LO, 8'h31, "async result");
        wr(OFF_SC2, 8'h40);
        wr(OFF_SC1, 8'h41);
        repeat (50) @(posedge aclk);
        chk("no soft start", conv_busy, 1'b0);
        sample_value <= 10'h0c8;
        hw_trigger <= 1'b1;
        repeat (4) @(posedge aclk);
        hw_trigger <= 1'b0;
        wait_irq(3000);
        chk("hw start", conv_irq, 1'b1);
        stop3_mode <= 1'b0;
        rchk(OFF_RES_LO, 8'h32, "hw result");
        wr(OFF_SC2, 8'h00);
        $display("test async stop done");
    endtask : t_async
    task t_block;
        sample_value <= 10'h155;
        wr(OFF_CFG, 8'h08);
        wr(OFF_SC1, 8'h61);
        wait_irq(200);
        rchk(OFF_RES_HI, 8'h01, "first high");
        sample_value <= 10'h2aa;
        repeat (200) @(posedge aclk);
        rchk(OFF_RES_LO, 8'h55, "held low");
        wait_irq(200);
        chk("next result", conv_irq, 1'b1);
        rchk(OFF_RES_HI, 8'h02, "new high");
        rchk(OFF_RES_LO, 8'haa, "new low");
        wr(OFF_SC1, 8'h1f);
        repeat (5) @(posedge aclk);
        chk("off busy", conv_busy, 1'b0);
        repeat (100) @(posedge aclk);
        rchk(OFF_SC1, 8'h1f, "off idle");
        $display("test blocking done");
    endtask : t_block
    task t_deep;
        wr(OFF_CFG, 8'h98);
        wr(OFF_PCTL1, 8'h02);
        wr(OFF_SC1, 8'h41);
        deep_stop <= 1'b1;
        repeat (5) @(posedge aclk);
        deep_stop <= 1'b0;
        @(posedge aclk);
        chk("deep pins", pin_disable, 16'h0000);
        chk("deep busy", conv_busy, 1'b0);
        rchk(OFF_CFG, 8'h00, "deep cfg");
        rchk(OFF_SC1, 8'h1f, "deep sc1");
        $display("test deep stop done");
    endtask : t_deep
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_regs();
        t_single();
        t_abort();
        t_compare();
        t_async();
        t_block();
        t_deep();
        close_out();
    end
endmodule : adc_ctrl_tb
